// ===== hw/lprs_top.sv
// Low-power mode control and reset-cause status of an 8-bit controller.
// Assumes the CPU core, break logic and reset sources share i_clk_sys;
// the crystal reference and the reset line arrive as asynchronous pins.
//
// Function
// - Wait or stop clears CPU interrupt mask
// - Wait stops CPU clock, peripherals keep running
// - Wait wake: stacking starts one cycle later
// - Reset or break ends wait; break sets flag
// - Watchdog enabled and running when option clear
// - Stop clears counter, gates both clock outputs
// - Stop ends on interrupt after recovery, on reset at once
// - Recovery 4096 crystal cycles, 32 if fast
// - Counter held cleared until recovery begins
// - Registers decoded at FE00, FE01, FE03
// - Break wakeup flag reads one after break exit
// - Reading reset cause clears all flags
// - Power-on sets its flag, clears others
// - One reset cause flag per source
// - Illegal address flag only on fetches
// - Monitor flag on erased vectors, high request
// - Drive reset line; sample 32 cycles later
// - Break clear enable guards flag clearing
// - Two-step clears stay guarded during break
`timescale 1ns/10ps
module lprs_top
  import lprs_pkg::*;
#(
  parameter logic [12:0] RST_DRIVE_XCYC = LPRS_RST_DRIVE_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // CPU register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  input wire logic i_wr,
  output logic [7:0] o_rdata,
  // CPU low-power and wake events
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic i_irq_req,
  input wire logic i_break_irq,
  input wire logic i_break_state,
  // Option bits
  input wire logic i_watchdog_disable_option,
  input wire logic i_fast_wake_select,
  // Reset sources
  input wire logic i_wdog_rst,
  input wire logic i_bad_op_rst,
  input wire logic i_bad_fetch,
  input wire logic i_bad_data,
  input wire logic i_low_v_rst,
  input wire logic i_vec_fetch_done,
  input wire logic [7:0] i_vec_hi,
  input wire logic [7:0] i_vec_lo,
  input wire logic i_irq_pin,
  // Crystal reference pin
  input wire logic i_crystal_clock_ref,
  // Open-drain reset line
  input wire logic i_rst_line_i,
  output logic o_rst_line_o,
  output logic o_rst_line_oe,
  // Clock gates and CPU controls
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_bus_clock_source_en,
  output logic o_crystal_clock_ref_en,
  output logic o_clr_int_mask,
  output logic o_stack_start,
  output logic o_int_reset,
  output logic o_wdog_en,
  output logic o_flag_clear_ok
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and functions

  // Power states of the core
  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT,
    ST_STOP_HOLD,
    ST_STOP_REC
  } lprs_pwr_e;

  // Reset line sequencer states
  typedef enum logic [1:0] {
    RS_IDLE,
    RS_DRIVE,
    RS_SETTLE
  } lprs_rs_e;

  // Address match for one register
  function automatic logic lprs_hit(input logic [15:0] addr, input logic [15:0] off);
    lprs_hit = (addr == off);
  endfunction : lprs_hit

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  lprs_pwr_e pwr_q; // Current power state
  lprs_pwr_e pwr_d; // Next power state
  lprs_rs_e rs_q; // Reset line state
  lprs_rs_e rs_d; // Next reset line state

  logic [7:0] rc_q; // reset_cause_reg
  logic [7:0] bs_q; // break_status_reg
  logic [7:0] bc_q; // break_flag_ctrl_reg
  logic [7:0] rdata_q; // Registered read data
  logic xtal_prev_q; // Last synced crystal level
  logic por_win_q; // First vector fetch since power-on pending

  logic cpu_clk_en_q; // Output flops
  logic periph_clk_en_q;
  logic gen_clk_en_q;
  logic clr_mask_q;
  logic stack_q;
  logic int_rst_q;
  logic rst_oe_q;
  logic rst_o_q;
  logic wdog_en_q;
  logic clr_ok_q;

  logic xtal_s; // Synced crystal reference
  logic rst_line_s; // Synced reset line
  logic stop_done; // Stop recovery count reached
  logic rs_done; // Reset line count reached

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Crystal reference is sampled, not used as a clock
  lprs_sync #(.W(2), .RST_VAL(2'b11)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async({i_crystal_clock_ref, i_rst_line_i}),
    .o_sync({xtal_s, rst_line_s})
  );

  // Rising edge of the crystal reference; limits it to below half i_clk_sys
  wire xtal_tick = xtal_s & ~xtal_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire hit_bs = lprs_hit(i_addr, LPRS_ADDR_BRK_STATUS);
  wire hit_rc = lprs_hit(i_addr, LPRS_ADDR_RST_CAUSE);
  wire hit_bc = lprs_hit(i_addr, LPRS_ADDR_BRK_CTRL);

  // Clearing allowed outside break, or in break when enabled
  wire clear_ok = ~i_break_state | bc_q[LPRS_BC_ENA_BIT];

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux = hit_bs ? bs_q :
                      hit_rc ? rc_q :
                      hit_bc ? bc_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources

  // Monitor entry: erased vectors with request line high after power-on
  wire mon_set = i_vec_fetch_done & por_win_q & i_irq_pin
               & (i_vec_hi == LPRS_MON_VEC) & (i_vec_lo == LPRS_MON_VEC);

  // Data accesses to illegal space are ignored here
  wire bad_fetch_set = i_bad_fetch;

  // Any internal source starts a reset line drive
  wire int_src = i_wdog_rst | i_bad_op_rst | bad_fetch_set | mon_set | i_low_v_rst;

  // Line pulled low by someone else while idle
  wire ext_low = (rs_q == RS_IDLE) & ~rst_line_s & ~int_src;

  // Late sample of the line after our own drive
  wire pin_late = (rs_q == RS_SETTLE) & rs_done & ~rst_line_s;

  // Per-source set vector
  wire [7:0] rc_set = ({7'h00, ext_low | pin_late} << LPRS_RC_PIN_BIT)
                    | ({7'h00, i_wdog_rst} << LPRS_RC_WDOG_BIT)
                    | ({7'h00, i_bad_op_rst} << LPRS_RC_BADOP_BIT)
                    | ({7'h00, bad_fetch_set} << LPRS_RC_BADADR_BIT)
                    | ({7'h00, mon_set} << LPRS_RC_MON_BIT)
                    | ({7'h00, i_low_v_rst} << LPRS_RC_LOWV_BIT);

  // Read clear, set wins in the same cycle
  wire rc_clr = i_rd & hit_rc & clear_ok;
  wire [7:0] rc_d = (rc_clr ? 8'h00 : rc_q) | rc_set;

  // Any reset returns the core to run
  wire any_reset = int_src | ext_low;

  ////////////////////////////////////////////////////////////////////////////
  // Break status and control

  // Break wakes from either low-power state
  wire in_low = (pwr_q != ST_RUN);
  wire bs_set = i_break_irq & in_low;
  // Writing zero clears the flag when clearing is allowed
  wire bs_clr = i_wr & hit_bs & ~i_wdata[LPRS_BS_WAKE_BIT] & clear_ok;
  wire bs_wake_d = (bs_q[LPRS_BS_WAKE_BIT] & ~bs_clr) | bs_set;
  wire [7:0] bs_d = {6'h00, bs_wake_d, 1'b0};

  // Control register write
  wire [7:0] bc_d = (i_wr & hit_bc) ? (i_wdata & 8'h80) : bc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine

  // Recovery length from the fast wake option
  wire [12:0] stop_limit = i_fast_wake_select ? LPRS_STOP_REC_SHORT
                                              : LPRS_STOP_REC_LONG;

  // Wake events
  wire wait_wake = (pwr_q == ST_WAIT) & (i_irq_req | i_break_irq);
  wire stop_wake = (pwr_q == ST_STOP_HOLD) & (i_irq_req | i_break_irq);
  wire rec_end = (pwr_q == ST_STOP_REC) & stop_done;
  wire lp_enter = (pwr_q == ST_RUN) & (i_wait_exec | i_stop_exec);

  // Next power state; reset exits any mode at once
  always_comb begin
    pwr_d = pwr_q;
    if (any_reset) begin
      pwr_d = ST_RUN;
    end else begin
      case (pwr_q)
        ST_RUN: begin
          if (i_stop_exec) begin
            pwr_d = ST_STOP_HOLD;
          end else if (i_wait_exec) begin
            pwr_d = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_wake) begin
            pwr_d = ST_RUN;
          end
        end
        ST_STOP_HOLD: begin
          if (stop_wake) begin
            pwr_d = ST_STOP_REC;
          end
        end
        ST_STOP_REC: begin
          if (stop_done) begin
            pwr_d = ST_RUN;
          end
        end
        default: begin
          pwr_d = ST_RUN;
        end
      endcase
    end
  end

  // Recovery counter is held clear until recovery starts
  wire stop_clr = (pwr_q != ST_STOP_REC);

  lprs_xcnt u_stop_cnt (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_clr(stop_clr),
    .i_tick(xtal_tick),
    .i_limit(stop_limit),
    .o_done(stop_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset line sequencer

  // Drive low, release, then wait before the late sample
  always_comb begin
    rs_d = rs_q;
    case (rs_q)
      RS_IDLE: begin
        if (int_src) begin
          rs_d = RS_DRIVE;
        end
      end
      RS_DRIVE: begin
        if (rs_done) begin
          rs_d = RS_SETTLE;
        end
      end
      RS_SETTLE: begin
        if (rs_done) begin
          rs_d = RS_IDLE;
        end
      end
      default: begin
        rs_d = RS_IDLE;
      end
    endcase
  end

  // Clear on idle and on the drive-to-settle step, so done drops in time
  wire rs_clr = (rs_q == RS_IDLE) | ((rs_q == RS_DRIVE) & rs_done);
  wire [12:0] rs_limit = (rs_q == RS_DRIVE) ? RST_DRIVE_XCYC
                                            : LPRS_PIN_SAMPLE_DLY;

  lprs_xcnt u_rs_cnt (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_clr(rs_clr),
    .i_tick(xtal_tick),
    .i_limit(rs_limit),
    .o_done(rs_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  // Power-on reset value: only the power-on flag set
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_q <= ST_RUN;
      rs_q <= RS_IDLE;
      rc_q <= LPRS_RC_RESET;
      bs_q <= LPRS_BS_RESET;
      bc_q <= LPRS_BC_RESET;
      xtal_prev_q <= 1'b1;
      por_win_q <= 1'b1;
    end else if (i_ce) begin
      pwr_q <= pwr_d;
      rs_q <= rs_d;
      rc_q <= rc_d;
      bs_q <= bs_d;
      bc_q <= bc_d;
      xtal_prev_q <= xtal_s;
      // Window closes after the first vector fetch
      if (i_vec_fetch_done) begin
        por_win_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  // Clock gates follow the next state so they switch with it
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cpu_clk_en_q <= 1'b1;
      periph_clk_en_q <= 1'b1;
      gen_clk_en_q <= 1'b1;
    end else if (i_ce) begin
      cpu_clk_en_q <= (pwr_d == ST_RUN);
      periph_clk_en_q <= (pwr_d == ST_RUN) | (pwr_d == ST_WAIT);
      gen_clk_en_q <= (pwr_d == ST_RUN) | (pwr_d == ST_WAIT);
    end
  end

  // One-cycle CPU pulses
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clr_mask_q <= 1'b0;
      stack_q <= 1'b0;
    end else if (i_ce) begin
      clr_mask_q <= lp_enter;
      // Stacking is suppressed when a reset coincides with the wake
      stack_q <= (wait_wake | rec_end) & ~any_reset;
    end
  end

  // Reset line, watchdog enable and clear permission
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_rst_q <= 1'b0;
      rst_oe_q <= 1'b0;
      rst_o_q <= 1'b0;
      wdog_en_q <= 1'b0;
      clr_ok_q <= 1'b1;
    end else if (i_ce) begin
      int_rst_q <= (rs_d == RS_DRIVE);
      rst_oe_q <= (rs_d == RS_DRIVE);
      rst_o_q <= 1'b0; // Open drain: only ever drives low
      // Independent of wait so the watchdog keeps counting there
      wdog_en_q <= ~i_watchdog_disable_option;
      // Other modules gate both steps of two-step clears on this
      clr_ok_q <= clear_ok;
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      rdata_q <= i_rd ? rd_mux : 8'h00;
    end
  end

  // Data-side illegal accesses leave the flags alone
  wire unused_ok = i_bad_data;

  assign o_rdata = rdata_q;
  assign o_cpu_clk_en = cpu_clk_en_q;
  assign o_periph_clk_en = periph_clk_en_q;
  assign o_bus_clock_source_en = gen_clk_en_q;
  assign o_crystal_clock_ref_en = gen_clk_en_q;
  assign o_clr_int_mask = clr_mask_q;
  assign o_stack_start = stack_q;
  assign o_int_reset = int_rst_q;
  assign o_rst_line_o = rst_o_q;
  assign o_rst_line_oe = rst_oe_q;
  assign o_wdog_en = wdog_en_q;
  assign o_flag_clear_ok = clr_ok_q;

endmodule : lprs_top

// ===== hw/lprs_pkg.sv
// Constants shared by the low-power and reset-status block.
// Assumes an 8-bit CPU bus with 16-bit addresses, one system clock.
package lprs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [15:0] LPRS_ADDR_BRK_STATUS = 16'hfe00; // break_status
  localparam logic [15:0] LPRS_ADDR_RST_CAUSE = 16'hfe01; // reset_cause
  localparam logic [15:0] LPRS_ADDR_BRK_CTRL = 16'hfe03; // break_flag_control

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause register bit positions
  localparam int LPRS_RC_POR_BIT = 7; // Power-on
  localparam int LPRS_RC_PIN_BIT = 6; // External reset line
  localparam int LPRS_RC_WDOG_BIT = 5; // Watchdog
  localparam int LPRS_RC_BADOP_BIT = 4; // Illegal opcode
  localparam int LPRS_RC_BADADR_BIT = 3; // Illegal address fetch
  localparam int LPRS_RC_MON_BIT = 2; // Monitor entry
  localparam int LPRS_RC_LOWV_BIT = 1; // Low voltage

  // Other register bit positions
  localparam int LPRS_BS_WAKE_BIT = 1; // Break wakeup flag in break_status
  localparam int LPRS_BC_ENA_BIT = 7; // Break clear enable in control reg

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] LPRS_RC_RESET = 8'h80; // Only power-on set
  localparam logic [7:0] LPRS_BS_RESET = 8'h00;
  localparam logic [7:0] LPRS_BC_RESET = 8'h00;
  localparam logic [7:0] LPRS_MON_VEC = 8'hff; // Erased vector byte value

  ////////////////////////////////////////////////////////////////////////////
  // Timing in crystal reference cycles
  localparam int LPRS_XCNT_W = 13;
  localparam logic [12:0] LPRS_STOP_REC_LONG = 13'h1000; // 4096 cycles
  localparam logic [12:0] LPRS_STOP_REC_SHORT = 13'h0020; // 32 cycles
  localparam logic [12:0] LPRS_PIN_SAMPLE_DLY = 13'h0020; // 32 cycles
  localparam logic [12:0] LPRS_RST_DRIVE_DEF = 13'h0010; // Reset line low time

endpackage : lprs_pkg

// ===== hw/lprs_sync.sv
// Two-stage synchroniser for asynchronous pin inputs.
// Assumes one system clock; the first stage feeds only the second.
`timescale 1ns/10ps
module lprs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q; // First stage, read only by the second
  logic [W-1:0] sync_q; // Second stage, safe for logic

  // Two flops in series
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (i_ce) begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : lprs_sync

// ===== hw/lprs_xcnt.sv
// Counter of crystal reference ticks with a registered done level.
// Assumes the tick is a one-cycle pulse in the system clock domain.
`timescale 1ns/10ps
module lprs_xcnt
  import lprs_pkg::*;
#(
  parameter int W = LPRS_XCNT_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_clr,
  input wire logic i_tick,
  input wire logic [W-1:0] i_limit,
  output logic o_done
);

  logic [W-1:0] cnt_q; // Ticks seen since clear
  logic done_q; // Limit reached, holds until clear
  wire [W-1:0] cnt_inc = cnt_q + 1'b1; // Next count

  // Clear wins; count only until done so the level stays put
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (i_ce) begin
      if (i_clr) begin
        cnt_q <= '0;
        done_q <= 1'b0;
      end else if (i_tick && !done_q) begin
        cnt_q <= cnt_inc;
        done_q <= (cnt_inc == i_limit);
      end
    end
  end

  assign o_done = done_q;

endmodule : lprs_xcnt

// ===== sim/lprs_sva.sv
// Port checker for lprs_top: clock gating, wake, reset drive, read data.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/10ps
module lprs_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic i_irq_req,
  input wire logic i_wdog_rst,
  input wire logic i_watchdog_disable_option,
  input wire logic [7:0] o_rdata,
  input wire logic o_rst_line_o,
  input wire logic o_rst_line_oe,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_bus_clock_source_en,
  input wire logic o_crystal_clock_ref_en,
  input wire logic o_clr_int_mask,
  input wire logic o_stack_start,
  input wire logic o_int_reset,
  input wire logic o_wdog_en
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Mode decode from the gate outputs
  wire run_w = o_cpu_clk_en && o_bus_clock_source_en; // All clocks on
  wire wait_w = !o_cpu_clk_en && o_periph_clk_en; // CPU clock off, peripherals on
  ////////////////////////////////////////////////////////////////////////////
  mask_clear_a:
    assert property (i_ce && run_w && (i_wait_exec || i_stop_exec) |=> o_clr_int_mask)
    else $error("mask clear missing");
  wait_gate_a:
    assert property (i_ce && run_w && i_wait_exec && !i_stop_exec |=> wait_w)
    else $error("wait gating wrong");
  wait_wake_a:
    assert property (i_ce && wait_w && i_irq_req && !i_wdog_rst |=> o_stack_start && o_cpu_clk_en)
    else $error("wait wake late");
  stack_pulse_a:
    assert property (o_stack_start |=> !o_stack_start)
    else $error("stack start not a pulse");
  stop_gate_a:
    assert property (i_ce && run_w && i_stop_exec |=> !o_cpu_clk_en && !o_periph_clk_en
      && !o_bus_clock_source_en && !o_crystal_clock_ref_en)
    else $error("stop gating wrong");
  stop_exit_a:
    assert property ($rose(o_bus_clock_source_en) |-> o_stack_start && o_cpu_clk_en)
    else $error("stop exit without stacking");
  wdog_follow_a:
    assert property (i_ce |=> o_wdog_en == !$past(i_watchdog_disable_option))
    else $error("watchdog enable wrong");
  rst_drive_a:
    assert property (i_ce && i_wdog_rst && !o_rst_line_oe |=> o_rst_line_oe && !o_rst_line_o)
    else $error("reset line not driven");
  drive_flag_a:
    assert property (o_rst_line_oe == o_int_reset)
    else $error("internal reset flag mismatch");
  rdata_idle_a:
    assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  unmapped_rd_a:
    assert property (i_ce && i_rd && i_addr == 16'hfe02 |=> o_rdata == 8'h00)
    else $error("unmapped read nonzero");
endmodule : lprs_sva

bind lprs_top lprs_sva u_sva (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_rd(i_rd),
  .i_wait_exec(i_wait_exec), .i_stop_exec(i_stop_exec), .i_irq_req(i_irq_req),
  .i_wdog_rst(i_wdog_rst), .i_watchdog_disable_option(i_watchdog_disable_option),
  .o_rdata(o_rdata), .o_rst_line_o(o_rst_line_o), .o_rst_line_oe(o_rst_line_oe),
  .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en),
  .o_bus_clock_source_en(o_bus_clock_source_en), .o_clr_int_mask(o_clr_int_mask),
  .o_crystal_clock_ref_en(o_crystal_clock_ref_en), .o_stack_start(o_stack_start),
  .o_int_reset(o_int_reset), .o_wdog_en(o_wdog_en)
);

// ===== sim/lprs_cpu_model.sv
// Far side model: crystal oscillator and the pulled-up reset line.
// Assumes the oscillator keeps running in stop, so fast wake is allowed.
`timescale 1ns/10ps
module lprs_cpu_model (
  input wire logic i_rst_line_oe,
  input wire logic i_ext_rst,
  output logic o_crystal,
  output logic o_rst_line
);
  // Free-running crystal, 122 ns period, unrelated to the system clock
  initial begin
    o_crystal = 1'b0;
    forever #61 o_crystal = !o_crystal;
  end
  // Open drain with pull-up: high unless someone pulls low
  assign o_rst_line = !(i_rst_line_oe || i_ext_rst);
endmodule : lprs_cpu_model

// ===== sim/testbench.sv
// Self-checking bench for lprs_top: registers, reset causes, wait, stop.
// Assumes the far side model supplies the crystal pin and reset line.
`timescale 1ns/10ps
module testbench;
  logic i_clk_sys, i_rst_n, i_ce, i_rd, i_wr, i_wait_exec, i_stop_exec, i_irq_req;
  logic i_break_irq, i_break_state, i_watchdog_disable_option, i_fast_wake_select;
  logic i_wdog_rst, i_bad_op_rst, i_bad_fetch, i_bad_data, i_low_v_rst, i_vec_fetch_done;
  logic i_irq_pin, ext_rst, xtal, rst_line;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, i_vec_hi, i_vec_lo;
  logic [7:0] o_rdata;
  logic rst_o, rst_oe, cpu_en, per_en, bus_en, xt_en, clr_mask, stack, int_rst, wdog_en, clr_ok;
  int errors = 0;
  int tests_run = 0;
  // Expected reset cause per source: watchdog, opcode, fetch, data, voltage
  logic [7:0] src_exp [5] = '{8'h20, 8'h10, 8'h08, 8'h00, 8'h02};

  ////////////////////////////////////////////////////////////////////////////
  // Short reset drive keeps each reset cause test brief
  lprs_top #(.RST_DRIVE_XCYC(13'h0002)) uut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_rd(i_rd), .i_wr(i_wr), .o_rdata(o_rdata),
    .i_wait_exec(i_wait_exec), .i_stop_exec(i_stop_exec), .i_irq_req(i_irq_req),
    .i_break_irq(i_break_irq), .i_break_state(i_break_state),
    .i_watchdog_disable_option(i_watchdog_disable_option),
    .i_fast_wake_select(i_fast_wake_select), .i_wdog_rst(i_wdog_rst),
    .i_bad_op_rst(i_bad_op_rst), .i_bad_fetch(i_bad_fetch), .i_bad_data(i_bad_data),
    .i_low_v_rst(i_low_v_rst), .i_vec_fetch_done(i_vec_fetch_done), .i_vec_hi(i_vec_hi),
    .i_vec_lo(i_vec_lo), .i_irq_pin(i_irq_pin), .i_crystal_clock_ref(xtal),
    .i_rst_line_i(rst_line), .o_rst_line_o(rst_o), .o_rst_line_oe(rst_oe),
    .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en), .o_bus_clock_source_en(bus_en),
    .o_crystal_clock_ref_en(xt_en), .o_clr_int_mask(clr_mask), .o_stack_start(stack),
    .o_int_reset(int_rst), .o_wdog_en(wdog_en), .o_flag_clear_ok(clr_ok)
  );
  lprs_cpu_model u_far (
    .i_rst_line_oe(rst_oe), .i_ext_rst(ext_rst), .o_crystal(xtal), .o_rst_line(rst_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // Inputs always change 1 ns after the rising edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // Leading tick keeps two strobes apart by one edge
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    tick();
    i_addr = a;
    i_rd = 1'b1;
    tick();
    i_rd = 1'b0;
    check($sformatf("read %h", a), e, o_rdata);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    tick();
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    tick();
    i_wr = 1'b0;
  endtask : wr

  // Stop, idle, then wake; recovery measured from the wake request
  task automatic stop_wake(input logic f, input int lo, input int hi);
    int n;
    n = 0;
    i_fast_wake_select = f;
    i_stop_exec = 1'b1;
    tick();
    i_stop_exec = 1'b0;
    check("stop gates", 8'h01, {3'h0, cpu_en, per_en, bus_en, xt_en, clr_mask});
    tick(50);
    i_irq_req = 1'b1;
    do begin
      tick();
      n++;
    end while (stack !== 1'b1 && n < 30000);
    i_irq_req = 1'b0;
    tests_run++;
    if (n < lo || n > hi) begin
      errors++;
      $display("CHECK FAILED stop recovery expected %0d to %0d seen %0d", lo, hi, n);
    end
  endtask : stop_wake

  task automatic final_report;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // Hang guard, well beyond the 27.5k cycles the tests need
  initial begin
    #1000000;
    errors++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {i_rd, i_wr, i_wait_exec, i_stop_exec, i_irq_req, i_break_irq, i_break_state} = '0;
    {i_wdog_rst, i_bad_op_rst, i_bad_fetch, i_bad_data, i_low_v_rst, i_vec_fetch_done} = '0;
    {i_watchdog_disable_option, i_fast_wake_select, ext_rst} = '0;
    {i_addr, i_wdata, i_vec_hi, i_vec_lo} = '0;
    i_ce = 1'b1;
    i_irq_pin = 1'b1;
    i_rst_n = 1'b0;
    tick(16);
    i_rst_n = 1'b1;
    // Reset values, unmapped place, read clear
    rd(16'hfe00, 8'h00);
    rd(16'hfe03, 8'h00);
    rd(16'hfe02, 8'h00);
    rd(16'hfe01, 8'h80);
    rd(16'hfe01, 8'h00);
    // Erased vectors with request line high on the first fetch
    {i_vec_hi, i_vec_lo, i_vec_fetch_done} = {16'hffff, 1'b1};
    tick();
    i_vec_fetch_done = 1'b0;
    tick(260);
    rd(16'hfe01, 8'h04);
    // One flag per source; a data access sets none
    for (int k = 0; k < 5; k++) begin
      {i_wdog_rst, i_bad_op_rst, i_bad_fetch, i_bad_data, i_low_v_rst} = 5'h10 >> k;
      tick();
      {i_wdog_rst, i_bad_op_rst, i_bad_fetch, i_bad_data, i_low_v_rst} = 5'h00;
      tick(260);
      rd(16'hfe01, src_exp[k]);
    end
    // Line pulled low from outside
    ext_rst = 1'b1;
    tick(4);
    ext_rst = 1'b0;
    tick(5);
    rd(16'hfe01, 8'h40);
    // Break with clearing disabled keeps the flag until break ends
    i_break_state = 1'b1;
    i_wdog_rst = 1'b1;
    tick();
    i_wdog_rst = 1'b0;
    tick(260);
    rd(16'hfe01, 8'h20);
    rd(16'hfe01, 8'h20);
    check("clear ok", 8'h00, {7'h0, clr_ok});
    i_break_state = 1'b0;
    rd(16'hfe01, 8'h20);
    rd(16'hfe01, 8'h00);
    // Break with clearing enabled
    i_break_state = 1'b1;
    wr(16'hfe03, 8'h80);
    rd(16'hfe03, 8'h80);
    check("clear ok", 8'h01, {7'h0, clr_ok});
    i_low_v_rst = 1'b1;
    tick();
    i_low_v_rst = 1'b0;
    tick(260);
    rd(16'hfe01, 8'h02);
    rd(16'hfe01, 8'h00);
    wr(16'hfe03, 8'h00);
    i_break_state = 1'b0;
    // Wait entry and interrupt wake
    i_wait_exec = 1'b1;
    tick();
    i_wait_exec = 1'b0;
    check("wait gates", 8'h0b, {4'h0, clr_mask, cpu_en, per_en, wdog_en});
    tick(3);
    i_irq_req = 1'b1;
    tick();
    i_irq_req = 1'b0;
    check("wait wake", 8'h03, {6'h0, stack, cpu_en});
    // Break ends wait and sets the wake flag, cleared by writing 0
    tick(3);
    i_wait_exec = 1'b1;
    tick();
    i_wait_exec = 1'b0;
    tick(2);
    i_break_irq = 1'b1;
    tick();
    i_break_irq = 1'b0;
    rd(16'hfe00, 8'h02);
    wr(16'hfe00, 8'h00);
    rd(16'hfe00, 8'h00);
    // Watchdog follows the option bit
    i_watchdog_disable_option = 1'b1;
    tick(2);
    check("watchdog", 8'h00, {7'h0, wdog_en});
    i_watchdog_disable_option = 1'b0;
    // Stop recovery: 32 then 4096 crystal edges of 6.1 cycles each,
    // plus entry and done latency; crystal phase moves it by one period
    stop_wake(1'b1, 191, 200);
    tick(5);
    stop_wake(1'b0, 24981, 24990);
    tick(5);
    final_report();
  end
endmodule : testbench
